/* File: shared/sfm_pkg.sv */
package sfm_pkg;

  // Control register byte: bit 7 is write enable, the rest are fields.
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam int         CTRL_WR_EN_BIT   = 7;
  localparam int         CTRL_FAULT_BIT   = 6;
  localparam int         CTRL_SLEEP_BIT   = 5;
  localparam int         CTRL_SHDN_SEL_BIT = 4;
  localparam int         CTRL_HV_DIS_BIT  = 3;
  localparam int         CTRL_VOSET_BIT   = 2;
  localparam int         CTRL_PUMP_EN_BIT = 1;
  localparam int         CTRL_OCSET_BIT   = 0;

  // Register map of the plain register port.
  localparam logic [3:0] ADDR_STATE   = 4'h0;
  localparam logic [3:0] ADDR_CTRL    = 4'h1;
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h2;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h3;
  localparam logic [3:0] ADDR_IRQ_EN  = 4'h4;
  localparam logic [3:0] ADDR_STATUS  = 4'h5;

  localparam logic [7:0] STATE_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET   = 2'h0;

  // Interrupt status bits.
  localparam int IRQ_FAULT_BIT    = 0;
  localparam int IRQ_SHUTDOWN_BIT = 1;

  typedef enum logic [2:0] {
    SFM_ARMING  = 3'h1,
    SFM_RUN     = 3'h2,
    SFM_TRIPPED = 3'h4
  } sfm_phase_t;

endpackage : sfm_pkg

/* File: src/sfm_supply_fault_monitor.sv */
`timescale 1ns/10ps

module sfm_supply_fault_monitor (
  input  wire logic       clk,                 // 10 MHz device clock
  input  wire logic       rst_n,               // Asynchronous reset, active low
  input  wire logic       serial_mode,         // 1 = serial control, 0 = pin control
  input  wire logic       core_ok_raw,         // Core comparator, 1 = above threshold
  input  wire logic       hv_ok_raw,           // High-voltage comparator, 1 = above threshold
  input  wire logic       pump_enable_pin,     // Pump enable pin, pin-control mode
  input  wire logic       shutdown_select_pin, // Shutdown select pin, pin-control mode
  input  wire logic [7:0] gpio_outputs,        // Output pattern for the channels in pin-control mode, forced to 0 while tripped
  input  wire logic [3:0] reg_addr,            // Register address
  input  wire logic [7:0] reg_wdata,           // Register write data
  input  wire logic       reg_wr,              // Write strobe
  input  wire logic       reg_rd,              // Read strobe
  output logic      [7:0] reg_rdata,           // Read data, cycle after strobe
  output logic            fault_out_n_o,       // Fault pin output value, always 0
  output logic            fault_out_n_oe_n,    // Fault pin enable, low while driving
  output logic      [7:0] hv_outputs,          // Eight high-voltage channel controls
  output logic            pump_run,            // Charge pump enable to analog
  output logic            irq                  // Level interrupt
);

  typedef struct packed {
    logic                core_s1;
    logic                core_s2;
    logic                hv_s1;
    logic                hv_s2;
    logic                pin_pump_s1;
    logic                pin_pump_s2;
    logic                pin_shdn_s1;
    logic                pin_shdn_s2;
    sfm_pkg::sfm_phase_t phase;
    logic                core_armed;
    logic                hv_armed;
    logic [7:0]          ctrl;
    logic [7:0]          state;
    logic                tripped_pump_seen_low;
    logic [1:0]          irq_status;
    logic [1:0]          irq_enable;
    logic [7:0]          rdata;
    logic                fault_oe_n;
    logic [7:0]          hv_out;
    logic                pump;
    logic                irq;
  } sfm_state_t;

  sfm_state_t cur;
  sfm_state_t next_cur;

  function automatic logic [7:0] sfm_with_bit(input logic [7:0] v, input int idx, input logic b);
    logic [7:0] r;
    r      = v;
    r[idx] = b;
    return r;
  endfunction : sfm_with_bit

  // One decode for every register write, so all addresses share the same strobe qualification.
  function automatic logic sfm_wr_hit(input logic       wr,
                                      input logic [3:0] addr,
                                      input logic [3:0] target);
    return wr && (addr == target);
  endfunction : sfm_wr_hit

  logic pump_en_eff;
  logic shdn_sel_eff;
  logic hv_ignored;
  logic core_fault;
  logic hv_fault;
  logic fault_now;
  logic ctrl_write;
  logic shutdown_event;

  always_comb begin
    next_cur = cur;

    next_cur.core_s1     = core_ok_raw;
    next_cur.core_s2     = cur.core_s1;
    next_cur.hv_s1       = hv_ok_raw;
    next_cur.hv_s2       = cur.hv_s1;
    next_cur.pin_pump_s1 = pump_enable_pin;
    next_cur.pin_pump_s2 = cur.pin_pump_s1;
    next_cur.pin_shdn_s1 = shutdown_select_pin;
    next_cur.pin_shdn_s2 = cur.pin_shdn_s1;

    // Serial mode takes its controls from the register, not from the pins.
    pump_en_eff  = serial_mode ? cur.ctrl[sfm_pkg::CTRL_PUMP_EN_BIT]
                               : cur.pin_pump_s2;
    shdn_sel_eff = serial_mode ? cur.ctrl[sfm_pkg::CTRL_SHDN_SEL_BIT]
                               : cur.pin_shdn_s2;
    hv_ignored   = serial_mode ? cur.ctrl[sfm_pkg::CTRL_HV_DIS_BIT]
                               : !cur.pin_pump_s2;

    // Each supply arms on its own; faults count only once both have armed, then a core fault always, an hv fault only while hv_ignored is clear.
    if (cur.core_s2) begin
      next_cur.core_armed = 1'b1;
    end
    if (cur.hv_s2) begin
      next_cur.hv_armed = 1'b1;
    end
    core_fault = cur.core_armed && !cur.core_s2;
    hv_fault   = cur.hv_armed && !cur.hv_s2 && !hv_ignored;
    fault_now  = (cur.phase != sfm_pkg::SFM_ARMING) && (core_fault || hv_fault);

    ctrl_write     = sfm_wr_hit(reg_wr, reg_addr, sfm_pkg::ADDR_CTRL);
    shutdown_event = 1'b0;

    // Host writes: the status bit can only be written to 0, never set by software.
    if (sfm_wr_hit(reg_wr, reg_addr, sfm_pkg::ADDR_STATE)) begin
      next_cur.state = reg_wdata;
    end
    if (ctrl_write && reg_wdata[sfm_pkg::CTRL_WR_EN_BIT]) begin
      next_cur.ctrl = sfm_with_bit(reg_wdata, sfm_pkg::CTRL_FAULT_BIT,
                                   cur.ctrl[sfm_pkg::CTRL_FAULT_BIT] &&
                                   reg_wdata[sfm_pkg::CTRL_FAULT_BIT]);
      next_cur.ctrl[sfm_pkg::CTRL_WR_EN_BIT] = 1'b0;
    end
    if (!serial_mode) begin
      next_cur.ctrl[sfm_pkg::CTRL_SLEEP_BIT] = 1'b0;
    end

    case (cur.phase)
      sfm_pkg::SFM_ARMING: begin
        if (cur.core_armed && cur.hv_armed) begin
          next_cur.phase = sfm_pkg::SFM_RUN;
        end
      end
      sfm_pkg::SFM_RUN: begin
        if (fault_now && !shdn_sel_eff) begin
          next_cur.phase                 = sfm_pkg::SFM_TRIPPED;
          next_cur.tripped_pump_seen_low = 1'b0;
          shutdown_event                 = 1'b1;
        end
      end
      sfm_pkg::SFM_TRIPPED: begin
        // Restart needs a full low then high on the pump enable.
        if (!pump_en_eff) begin
          next_cur.tripped_pump_seen_low = 1'b1;
        end else if (cur.tripped_pump_seen_low && !fault_now) begin
          next_cur.phase = sfm_pkg::SFM_RUN;
        end
      end
      default: begin
        next_cur.phase = sfm_pkg::SFM_ARMING;
      end
    endcase

    // A fault set in the same cycle as a clearing write wins.
    if (fault_now) begin
      next_cur.ctrl[sfm_pkg::CTRL_FAULT_BIT] = 1'b1;
    end

    next_cur.fault_oe_n = !fault_now;

    if (next_cur.phase == sfm_pkg::SFM_TRIPPED) begin
      next_cur.hv_out = 8'h00;
      next_cur.pump   = 1'b0;
    end else begin
      next_cur.hv_out = serial_mode ? next_cur.state : gpio_outputs;
      next_cur.pump   = pump_en_eff;
    end

    // The clear is applied first so that an event in the same cycle wins over it.
    if (sfm_wr_hit(reg_wr, reg_addr, sfm_pkg::ADDR_IRQ_CLR)) begin
      next_cur.irq_status = cur.irq_status & ~reg_wdata[1:0];
    end
    if (fault_now && !cur.ctrl[sfm_pkg::CTRL_FAULT_BIT]) begin
      next_cur.irq_status[sfm_pkg::IRQ_FAULT_BIT] = 1'b1;
    end
    if (shutdown_event) begin
      next_cur.irq_status[sfm_pkg::IRQ_SHUTDOWN_BIT] = 1'b1;
    end
    if (sfm_wr_hit(reg_wr, reg_addr, sfm_pkg::ADDR_IRQ_EN)) begin
      next_cur.irq_enable = reg_wdata[1:0];
    end
    next_cur.irq = |(next_cur.irq_status & next_cur.irq_enable);

    next_cur.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        sfm_pkg::ADDR_STATE:  next_cur.rdata = cur.state;
        sfm_pkg::ADDR_CTRL:   next_cur.rdata = cur.ctrl;
        sfm_pkg::ADDR_IRQ_ST: next_cur.rdata = {6'h00, cur.irq_status};
        sfm_pkg::ADDR_IRQ_EN: next_cur.rdata = {6'h00, cur.irq_enable};
        sfm_pkg::ADDR_STATUS: next_cur.rdata = {3'h0, cur.phase, core_fault, hv_fault};
        default:              next_cur.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur                       <= '0;
      cur.phase                 <= sfm_pkg::SFM_ARMING;
      cur.ctrl                  <= sfm_pkg::CTRL_RESET;
      cur.state                 <= sfm_pkg::STATE_RESET;
      cur.irq_status            <= sfm_pkg::IRQ_RESET;
      cur.irq_enable            <= sfm_pkg::IRQ_RESET;
      cur.fault_oe_n            <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata        = cur.rdata;
  assign fault_out_n_o    = 1'b0;
  assign fault_out_n_oe_n = cur.fault_oe_n;
  assign hv_outputs       = cur.hv_out;
  assign pump_run         = cur.pump;
  assign irq              = cur.irq;

endmodule : sfm_supply_fault_monitor

/* File: dv/sfm_asserts.sv */
`timescale 1ns/10ps
module sfm_asserts (
  input wire logic       clk,                 // Clock
  input wire logic       rst_n,               // Reset
  input wire logic       serial_mode,         // Mode
  input wire logic       core_ok_raw,         // Core good
  input wire logic       hv_ok_raw,           // HV good
  input wire logic       pump_enable_pin,     // Pump pin
  input wire logic       shutdown_select_pin, // Select pin
  input wire logic       reg_rd,              // Read strobe
  input wire logic [7:0] reg_rdata,           // Read data
  input wire logic       fault_out_n_o,       // Pin value
  input wire logic       fault_out_n_oe_n,    // Pin enable
  input wire logic [7:0] hv_outputs,          // Channels
  input wire logic       pump_run             // Pump
);
  logic [1:0] good_cnt;
  logic       seen_good;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Three good samples in a row outlast the design's synchronisers, so it is armed by then.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      good_cnt  <= 2'h0;
      seen_good <= 1'b0;
    end else if (core_ok_raw && hv_ok_raw) begin
      seen_good <= 1'b1;
      good_cnt  <= (good_cnt == 2'h3) ? good_cnt : good_cnt + 2'h1;
    end else if (good_cnt != 2'h3) begin
      good_cnt <= 2'h0;
    end
  end
  property p_pin_low; fault_out_n_o == 1'b0; endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin value not low");
  property p_rel; (core_ok_raw && hv_ok_raw) [*4] |-> fault_out_n_oe_n; endproperty
  a_rel: assert property (p_rel) else $error("pin not released");
  property p_noarm; !seen_good |-> fault_out_n_oe_n; endproperty
  a_noarm: assert property (p_noarm) else $error("fault before arming");
  property p_lat;
    $fell(core_ok_raw) && hv_ok_raw && good_cnt == 2'h3 && fault_out_n_oe_n
      |=> fault_out_n_oe_n [*2] ##1 !fault_out_n_oe_n;
  endproperty
  a_lat: assert property (p_lat) else $error("fault pin timing wrong");
  property p_hvign;
    (!serial_mode && !pump_enable_pin && core_ok_raw) [*4] |-> fault_out_n_oe_n;
  endproperty
  a_hvign: assert property (p_hvign) else $error("hv fault not ignored");
  property p_shdn;
    (!serial_mode && !shutdown_select_pin) [*4] ##0 !fault_out_n_oe_n
      |-> hv_outputs == 8'h00 && !pump_run;
  endproperty
  a_shdn: assert property (p_shdn) else $error("no shutdown on fault");
  property p_rep;
    (!serial_mode && shutdown_select_pin && pump_enable_pin) [*4] ##0 $fell(fault_out_n_oe_n)
      |-> $stable(hv_outputs) && $stable(pump_run);
  endproperty
  a_rep: assert property (p_rep) else $error("report only fault acted");
  property p_rd; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
endmodule : sfm_asserts

/* File: dv/sfm_host.sv */
`timescale 1ns/10ps
module sfm_host (
  input  wire logic       clk,       // Clock
  input  wire logic [7:0] reg_rdata, // Read data
  output logic      [3:0] reg_addr,  // Address
  output logic      [7:0] reg_wdata, // Write data
  output logic            reg_wr,    // Write strobe
  output logic            reg_rd     // Read strobe
);
  initial begin
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // A restart needs both edges of the enable bit, so it is always two writes.
  task automatic restart(input logic [7:0] c);
    wr(sfm_pkg::ADDR_CTRL, c & 8'hFD);
    wr(sfm_pkg::ADDR_CTRL, c | 8'h02);
  endtask : restart
endmodule : sfm_host

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} sfm_row_t;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       serial_mode = 1'b1;
  logic       core_ok_raw = 1'b0;
  logic       hv_ok_raw = 1'b0;
  logic       pump_enable_pin = 1'b1;
  logic       shutdown_select_pin = 1'b1;
  logic [7:0] gpio_outputs = 8'h5A;
  logic       reg_wr, reg_rd, fault_out_n_o, fault_out_n_oe_n, pump_run, irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, hv_outputs, rv, hv_prev;
  int         num_errors = 0;
  int         n_checks = 0;
  sfm_row_t   rows [4] = '{'{sfm_pkg::ADDR_CTRL, 8'h9E, 8'h1E}, '{sfm_pkg::ADDR_CTRL, 8'h1F,
    8'h1E}, '{sfm_pkg::ADDR_IRQ_EN, 8'h03, 8'h03}, '{4'hF, 8'h55, 8'h00}};
  always #50 clk = ~clk;
  sfm_supply_fault_monitor sfm_supply_fault_monitor_inst (.clk, .rst_n, .serial_mode,
    .core_ok_raw, .hv_ok_raw, .pump_enable_pin, .shutdown_select_pin, .gpio_outputs,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fault_out_n_o, .fault_out_n_oe_n,
    .hv_outputs, .pump_run, .irq);
  sfm_host sfm_host_inst (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic chb(input string n, input logic e, input logic s);
    chk(n, {7'h00, e}, {7'h00, s});
  endtask : chb
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Pin code order is core, hv, pump enable, shutdown select.
  task automatic drv(input logic [3:0] v);
    @(posedge clk);
    {core_ok_raw, hv_ok_raw, pump_enable_pin, shutdown_select_pin} <= v;
  endtask : drv
  task automatic wait_oe(input logic v);
    for (int i = 0; i < 10 && fault_out_n_oe_n !== v; i++) cyc(1);
    chb("oe_n", v, fault_out_n_oe_n);
    if (fault_out_n_oe_n !== v) end_sim();
  endtask : wait_oe
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    sfm_host_inst.rd(a, rv);
    chk("rdata", e, rv);
  endtask : rchk
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rchk(sfm_pkg::ADDR_CTRL, sfm_pkg::CTRL_RESET);
    cyc(6);
    chb("oe_n", 1'b1, fault_out_n_oe_n);
    drv(4'hF);
    cyc(4);
    foreach (rows[i]) begin
      sfm_host_inst.wr(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    $display("Test registers done");
    sfm_host_inst.wr(sfm_pkg::ADDR_CTRL, 8'h82);
    cyc(3);
    chb("pump", 1'b1, pump_run);
    drv(4'h7);
    wait_oe(1'b0);
    chk("hv", 8'h00, hv_outputs);
    chb("pump", 1'b0, pump_run);
    chb("irq", 1'b1, irq);
    rchk(sfm_pkg::ADDR_CTRL, 8'h42);
    drv(4'hF);
    wait_oe(1'b1);
    sfm_host_inst.wr(sfm_pkg::ADDR_CTRL, 8'hC2);
    rchk(sfm_pkg::ADDR_CTRL, 8'h42);
    sfm_host_inst.wr(sfm_pkg::ADDR_CTRL, 8'h82);
    rchk(sfm_pkg::ADDR_CTRL, 8'h02);
    chb("pump", 1'b0, pump_run);
    sfm_host_inst.restart(8'h82);
    cyc(2);
    chb("pump", 1'b1, pump_run);
    rchk(sfm_pkg::ADDR_IRQ_ST, 8'h03);
    sfm_host_inst.wr(sfm_pkg::ADDR_IRQ_CLR, 8'h03);
    cyc(1);
    chb("irq", 1'b0, irq);
    sfm_host_inst.wr(sfm_pkg::ADDR_CTRL, 8'h8A);
    drv(4'hB);
    cyc(6);
    chb("oe_n", 1'b1, fault_out_n_oe_n);
    drv(4'hF);
    @(posedge clk) serial_mode <= 1'b0;
    sfm_host_inst.wr(sfm_pkg::ADDR_IRQ_EN, 8'h00);
    cyc(4);
    hv_prev = hv_outputs;
    drv(4'hB);
    wait_oe(1'b0);
    chk("hv", hv_prev, hv_outputs);
    chb("pump", 1'b1, pump_run);
    chb("irq", 1'b0, irq);
    rchk(sfm_pkg::ADDR_IRQ_ST, 8'h01);
    sfm_host_inst.wr(sfm_pkg::ADDR_IRQ_EN, 8'h01);
    cyc(2);
    chb("irq", 1'b1, irq);
    drv(4'h3);
    cyc(4);
    drv(4'hB);
    cyc(6);
    chb("oe_n", 1'b0, fault_out_n_oe_n);
    drv(4'hF);
    wait_oe(1'b1);
    drv(4'h9);
    cyc(6);
    chb("oe_n", 1'b1, fault_out_n_oe_n);
    drv(4'hE);
    cyc(4);
    drv(4'h6);
    wait_oe(1'b0);
    chk("hv", 8'h00, hv_outputs);
    chb("pump", 1'b0, pump_run);
    drv(4'hC);
    cyc(6);
    drv(4'hE);
    cyc(5);
    chb("pump", 1'b1, pump_run);
    $display("Test faults done");
    @(posedge clk) rst_n <= 1'b0;
    cyc(2);
    chb("pump", 1'b0, pump_run);
    chk("hv", 8'h00, hv_outputs);
    chb("irq", 1'b0, irq);
    @(posedge clk) rst_n <= 1'b1;
    rchk(sfm_pkg::ADDR_CTRL, sfm_pkg::CTRL_RESET);
    chb("oe_n", 1'b1, fault_out_n_oe_n);
    $display("Test reset done");
    end_sim();
  end
endmodule : tb_top
bind sfm_supply_fault_monitor sfm_asserts sfm_asserts_inst (.clk, .rst_n, .serial_mode,
  .core_ok_raw, .hv_ok_raw, .pump_enable_pin, .shutdown_select_pin, .reg_rd, .reg_rdata,
  .fault_out_n_o, .fault_out_n_oe_n, .hv_outputs, .pump_run);
